/* design/ioc_pkg.sv */
`default_nettype none
package ioc_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_ELEM_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MODE     = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h8;

  // ---------------------------------------------------------------
  // Storage element options
  // ---------------------------------------------------------------
  typedef struct packed {
    logic init_explicit;
    logic init_high;
    logic force_high;
    logic force_async;
    logic is_latch;
  } ioc_elem_cfg_t;

  localparam int unsigned ELEM_CFG_W = 5;
  localparam int unsigned NUM_ELEM   = 6;
  localparam int unsigned ELEM_REG_W = ELEM_CFG_W * NUM_ELEM;
  localparam logic [ELEM_REG_W-1:0] ELEM_REG_RESET = 30'h00000000;

  localparam int unsigned EL_OUT_UP = 0;
  localparam int unsigned EL_OUT_LO = 1;
  localparam int unsigned EL_OE_UP  = 2;
  localparam int unsigned EL_OE_LO  = 3;
  localparam int unsigned EL_IN_UP  = 4;
  localparam int unsigned EL_IN_LO  = 5;

  // ---------------------------------------------------------------
  // Cell mode
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ce_connected;
    logic       invert_lower;
    logic       diff_standard;
    logic       cascade;
    logic       ddr_in;
    logic       ddr_oe;
    logic       ddr_out;
  } ioc_mode_t;

  localparam int unsigned MODE_W = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 9'h000;
  localparam int unsigned CE_OUT = 0;
  localparam int unsigned CE_OE  = 1;
  localparam int unsigned CE_IN  = 2;

  // Clock line indices
  localparam int unsigned CK_OUT_UP = 0;
  localparam int unsigned CK_OUT_LO = 1;
  localparam int unsigned CK_IN_UP  = 2;
  localparam int unsigned CK_IN_LO  = 3;
  localparam int unsigned NUM_CK    = 4;

  localparam int unsigned STATUS_W = 12;

  // Force controls shared by every element
  typedef struct packed {
    logic global_force;
    logic force_line;
    logic reverse_force_line;
  } ioc_force_t;

endpackage
`default_nettype wire

/* design/ioc_store_elem.sv */
`timescale 1ns/1ps
`default_nettype none
module ioc_store_elem (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire ioc_pkg::ioc_elem_cfg_t cfg_i,
  input  wire ioc_pkg::ioc_force_t    ctl_i,
  input  wire logic                  edge_i,
  input  wire logic                  gate_i,
  input  wire logic                  ce_i,
  input  wire logic                  d_i,
  output logic                       q_o
);
  import ioc_pkg::*;

  // ---------------------------------------------------------------
  // Load, force and initial value
  // ---------------------------------------------------------------
  wire logic active     = cfg_i.is_latch ? gate_i : edge_i;
  wire logic load_ok    = active & ce_i;
  wire logic any_force  = ctl_i.force_line | ctl_i.reverse_force_line;
  wire logic force_both = ctl_i.force_line & ctl_i.reverse_force_line;
  wire logic force_val  = force_both ? 1'b0 :
                          ctl_i.force_line ? cfg_i.force_high :
                          ~cfg_i.force_high;
  wire logic force_now  = any_force & (cfg_i.force_async | active);
  wire logic init_val   = cfg_i.init_explicit ? cfg_i.init_high :
                          cfg_i.force_high;
  wire logic next_q     = ctl_i.global_force ? init_val :
                          force_now ? force_val :
                          load_ok ? d_i : q_o;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_both_force_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (ctl_i.force_line && ctl_i.reverse_force_line && cfg_i.force_async
     && !ctl_i.global_force) |=> (q_o == 1'b0))
    else $error("force and reverse together did not give zero");

  a_global_init: assert property (@(posedge clk_i) disable iff (reset_i)
    ctl_i.global_force |=>
      (q_o == ($past(cfg_i.init_explicit) ? $past(cfg_i.init_high)
                                          : $past(cfg_i.force_high))))
    else $error("global force did not load the initial value");

  a_ce_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (!ce_i && !any_force && !ctl_i.global_force) |=> $stable(q_o))
    else $error("element changed with clock enable low");

  a_load_data: assert property (@(posedge clk_i) disable iff (reset_i)
    (active && ce_i && !any_force && !ctl_i.global_force)
      |=> (q_o == $past(d_i)))
    else $error("element did not load its data input");

endmodule // ioc_store_elem
`default_nettype wire

/* design/ioc_cell.sv */
// Notes on behaviour
// - Upper output and enable elements share the upper output clock.
// - Lower output and enable elements share the lower output clock.
// - Input elements have separate upper and lower input clocks.
// - One clock enable per path gates both elements of that path.
// - One force line and one reverse line reach all six elements.
// - Each element is a flip-flop or a transparent latch on its own.
// - Each element chooses synchronous or asynchronous forcing.
// - Force polarity per element; dual-edge output uses upper's for both.
// - Initial value on global force, by default following force polarity.
// - Dual-edge pair: a low initial value on one element lowers both.
// - Output registers plus multiplexer drive bits on both clock edges.
// - Two opposite clocks, or one clock plus the cell's own inverter.
// - Enable registers plus multiplexer change the enable on both edges.
// - Input registers on clock and inverse capture alternate bits.
// - First bit on upper input clock rise, second on lower rise.
// - Cascade re-registers the second bit on the upper input clock.
// - Cascade only inside a differential pair with differential standard.
// - Output bits registered on first and second clock, then multiplexed.
// - No edge alignment; behaves like the legacy dual-edge output.
// - Opposite constant bits on both edges forward a clock to the pin.
// - Force and reverse together give zero.
// - Reverse drives the opposite of the force value.
// - An unconnected clock enable behaves as always asserted.
// - A latch passes data while enabled and holds otherwise.
`timescale 1ns/1ps
`default_nettype none
module ioc_cell (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  // Register port
  input  wire logic [ioc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [ioc_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [ioc_pkg::DATA_W-1:0] reg_rdata_o,
  // Clock lines from outside the clock domain
  input  wire logic                       out_oe_clock_upper_i,
  input  wire logic                       out_oe_clock_lower_i,
  input  wire logic                       in_clock_upper_i,
  input  wire logic                       in_clock_lower_i,
  // Fabric side
  input  wire logic                       out_path_clock_enable_i,
  input  wire logic                       oe_path_clock_enable_i,
  input  wire logic                       in_path_clock_enable_i,
  input  wire logic                       force_line_i,
  input  wire logic                       reverse_force_line_i,
  input  wire logic                       global_force_i,
  input  wire logic                       first_edge_bit_i,
  input  wire logic                       second_edge_bit_i,
  input  wire logic                       oe_first_edge_bit_i,
  input  wire logic                       oe_second_edge_bit_i,
  output logic                            in_first_bit_o,
  output logic                            in_second_bit_o,
  // Pad
  input  wire logic                       pad_i,
  output logic                            pad_o,
  output logic                            pad_oe_n_o
);
  import ioc_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic ioc_elem_cfg_t elem_cfg(
    input logic [ELEM_REG_W-1:0] r,
    input int unsigned           idx
  );
    elem_cfg = r[idx*ELEM_CFG_W +: ELEM_CFG_W];
  endfunction

  function automatic logic init_of(input ioc_elem_cfg_t c);
    init_of = c.init_explicit ? c.init_high : c.force_high;
  endfunction

  // Options of one element of a dual-edge pair
  function automatic ioc_elem_cfg_t pair_cfg(
    input ioc_elem_cfg_t up,
    input ioc_elem_cfg_t lo,
    input logic          ddr,
    input logic          is_lower
  );
    ioc_elem_cfg_t c;
    c = is_lower ? lo : up;
    if (ddr) begin
      c.force_high    = up.force_high;
      c.init_explicit = 1'b1;
      c.init_high     = init_of(up) & init_of(lo);
    end
    pair_cfg = c;
  endfunction

  // Effective levels, lower lines optionally the inverse of upper
  function automatic logic [NUM_CK-1:0] eff_lvl(
    input logic [NUM_CK-1:0] v,
    input logic              inv
  );
    eff_lvl[CK_OUT_UP] = v[CK_OUT_UP];
    eff_lvl[CK_OUT_LO] = inv ? ~v[CK_OUT_UP] : v[CK_OUT_LO];
    eff_lvl[CK_IN_UP]  = v[CK_IN_UP];
    eff_lvl[CK_IN_LO]  = inv ? ~v[CK_IN_UP] : v[CK_IN_LO];
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [ELEM_REG_W-1:0] elem_reg;
  ioc_mode_t             mode;

  wire logic wr_elem = reg_wr_i & (reg_addr_i == ADDR_ELEM_CFG);
  wire logic wr_mode = reg_wr_i & (reg_addr_i == ADDR_MODE);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      elem_reg <= ELEM_REG_RESET;
      mode     <= MODE_RESET;
    end else begin
      if (wr_elem) begin
        elem_reg <= reg_wdata_i[ELEM_REG_W-1:0];
      end
      if (wr_mode) begin
        mode <= reg_wdata_i[MODE_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and clock edges
  // ---------------------------------------------------------------
  logic [NUM_CK-1:0] ck_meta;
  logic [NUM_CK-1:0] ck_sync;
  logic [NUM_CK-1:0] ck_prev;
  logic              pad_meta;
  logic              pad_sync;

  wire logic [NUM_CK-1:0] ck_raw = {in_clock_lower_i, in_clock_upper_i,
                                    out_oe_clock_lower_i,
                                    out_oe_clock_upper_i};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ck_meta  <= 4'h0;
      ck_sync  <= 4'h0;
      ck_prev  <= 4'h0;
      pad_meta <= 1'b0;
      pad_sync <= 1'b0;
    end else begin
      ck_meta  <= ck_raw;
      ck_sync  <= ck_meta;
      ck_prev  <= ck_sync;
      pad_meta <= pad_i;
      pad_sync <= pad_meta;
    end
  end

  wire logic [NUM_CK-1:0] lvl      = eff_lvl(ck_sync, mode.invert_lower);
  wire logic [NUM_CK-1:0] lvl_prev = eff_lvl(ck_prev, mode.invert_lower);
  wire logic [NUM_CK-1:0] ck_rise  = lvl & ~lvl_prev;

  // ---------------------------------------------------------------
  // Clock enables and force controls
  // ---------------------------------------------------------------
  wire logic ce_out = out_path_clock_enable_i | ~mode.ce_connected[CE_OUT];
  wire logic ce_oe  = oe_path_clock_enable_i  | ~mode.ce_connected[CE_OE];
  wire logic ce_in  = in_path_clock_enable_i  | ~mode.ce_connected[CE_IN];

  wire ioc_force_t ctl = '{global_force:       global_force_i,
                           force_line:         force_line_i,
                           reverse_force_line: reverse_force_line_i};

  // ---------------------------------------------------------------
  // Element wiring
  // ---------------------------------------------------------------
  ioc_elem_cfg_t       el_cfg [NUM_ELEM];
  logic [NUM_ELEM-1:0] el_edge;
  logic [NUM_ELEM-1:0] el_gate;
  logic [NUM_ELEM-1:0] el_ce;
  logic [NUM_ELEM-1:0] el_d;
  logic [NUM_ELEM-1:0] el_q;

  wire ioc_elem_cfg_t c_out_up = elem_cfg(elem_reg, EL_OUT_UP);
  wire ioc_elem_cfg_t c_out_lo = elem_cfg(elem_reg, EL_OUT_LO);
  wire ioc_elem_cfg_t c_oe_up  = elem_cfg(elem_reg, EL_OE_UP);
  wire ioc_elem_cfg_t c_oe_lo  = elem_cfg(elem_reg, EL_OE_LO);

  assign el_cfg[EL_OUT_UP] = pair_cfg(c_out_up, c_out_lo, mode.ddr_out,
                                      1'b0);
  assign el_cfg[EL_OUT_LO] = pair_cfg(c_out_up, c_out_lo, mode.ddr_out,
                                      1'b1);
  assign el_cfg[EL_OE_UP]  = pair_cfg(c_oe_up, c_oe_lo, mode.ddr_oe, 1'b0);
  assign el_cfg[EL_OE_LO]  = pair_cfg(c_oe_up, c_oe_lo, mode.ddr_oe, 1'b1);
  assign el_cfg[EL_IN_UP]  = elem_cfg(elem_reg, EL_IN_UP);
  assign el_cfg[EL_IN_LO]  = elem_cfg(elem_reg, EL_IN_LO);

  assign el_edge[EL_OUT_UP] = ck_rise[CK_OUT_UP];
  assign el_edge[EL_OE_UP]  = ck_rise[CK_OUT_UP];
  assign el_edge[EL_OUT_LO] = ck_rise[CK_OUT_LO];
  assign el_edge[EL_OE_LO]  = ck_rise[CK_OUT_LO];
  assign el_edge[EL_IN_UP]  = ck_rise[CK_IN_UP];
  assign el_edge[EL_IN_LO]  = ck_rise[CK_IN_LO];

  assign el_gate[EL_OUT_UP] = lvl[CK_OUT_UP];
  assign el_gate[EL_OE_UP]  = lvl[CK_OUT_UP];
  assign el_gate[EL_OUT_LO] = lvl[CK_OUT_LO];
  assign el_gate[EL_OE_LO]  = lvl[CK_OUT_LO];
  assign el_gate[EL_IN_UP]  = lvl[CK_IN_UP];
  assign el_gate[EL_IN_LO]  = lvl[CK_IN_LO];

  assign el_ce[EL_OUT_UP] = ce_out;
  assign el_ce[EL_OUT_LO] = ce_out;
  assign el_ce[EL_OE_UP]  = ce_oe;
  assign el_ce[EL_OE_LO]  = ce_oe;
  assign el_ce[EL_IN_UP]  = ce_in;
  assign el_ce[EL_IN_LO]  = ce_in;

  // Second bits arrive already retimed by the fabric
  assign el_d[EL_OUT_UP] = first_edge_bit_i;
  assign el_d[EL_OUT_LO] = second_edge_bit_i;
  assign el_d[EL_OE_UP]  = oe_first_edge_bit_i;
  assign el_d[EL_OE_LO]  = oe_second_edge_bit_i;
  assign el_d[EL_IN_UP]  = pad_sync;
  assign el_d[EL_IN_LO]  = pad_sync;

  for (genvar g = 0; g < NUM_ELEM; g++) begin : g_elem
    ioc_store_elem u_elem (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .cfg_i   (el_cfg[g]),
      .ctl_i   (ctl),
      .edge_i  (el_edge[g]),
      .gate_i  (el_gate[g]),
      .ce_i    (el_ce[g]),
      .d_i     (el_d[g]),
      .q_o     (el_q[g])
    );
  end

  // ---------------------------------------------------------------
  // Input cascade into the slave cell
  // ---------------------------------------------------------------
  logic slave_q;

  // Only inside a differential pair; no fabric route reaches it
  wire logic cascade_on = mode.ddr_in & mode.cascade & mode.diff_standard;

  ioc_store_elem u_slave (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .cfg_i   (el_cfg[EL_IN_UP]),
    .ctl_i   (ctl),
    .edge_i  (ck_rise[CK_IN_UP]),
    .gate_i  (lvl[CK_IN_UP]),
    .ce_i    (ce_in),
    .d_i     (el_q[EL_IN_LO]),
    .q_o     (slave_q)
  );

  // Without cascade the fabric brings the second bit across itself
  wire logic next_in_second = cascade_on ? slave_q : el_q[EL_IN_LO];

  // ---------------------------------------------------------------
  // Output and enable multiplexers
  // ---------------------------------------------------------------
  // Plain select on the first clock level, no edge alignment
  wire logic next_pad = (mode.ddr_out && !lvl[CK_OUT_UP]) ?
                        el_q[EL_OUT_LO] : el_q[EL_OUT_UP];
  wire logic next_oe_n = (mode.ddr_oe && !lvl[CK_OUT_UP]) ?
                         el_q[EL_OE_LO] : el_q[EL_OE_UP];

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  wire logic [STATUS_W-1:0] status = {pad_sync, lvl, slave_q, el_q};
  wire logic [DATA_W-1:0] rd_elem = {{(DATA_W-ELEM_REG_W){1'b0}}, elem_reg};
  wire logic [DATA_W-1:0] rd_mode = {{(DATA_W-MODE_W){1'b0}}, mode};
  wire logic [DATA_W-1:0] rd_stat = {{(DATA_W-STATUS_W){1'b0}}, status};
  wire logic [DATA_W-1:0] rd_sel  =
    (reg_addr_i == ADDR_ELEM_CFG) ? rd_elem :
    (reg_addr_i == ADDR_MODE)     ? rd_mode :
    (reg_addr_i == ADDR_STATUS)   ? rd_stat : {DATA_W{1'b0}};
  wire logic [DATA_W-1:0] next_rdata = reg_rd_i ? rd_sel : {DATA_W{1'b0}};

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pad_o           <= 1'b0;
      pad_oe_n_o      <= 1'b1;
      in_first_bit_o  <= 1'b0;
      in_second_bit_o <= 1'b0;
      reg_rdata_o     <= 32'h00000000;
    end else begin
      pad_o           <= next_pad;
      pad_oe_n_o      <= next_oe_n;
      in_first_bit_o  <= el_q[EL_IN_UP];
      in_second_bit_o <= next_in_second;
      reg_rdata_o     <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  wire logic quiet = !force_line_i && !reverse_force_line_i && !global_force_i;
  wire logic flop_out = !el_cfg[EL_OUT_UP].is_latch;
  wire logic flop_in  = !el_cfg[EL_IN_UP].is_latch && !el_cfg[EL_IN_LO].is_latch;

  sequence s_out_upper_load;
    ck_rise[CK_OUT_UP] && ce_out && quiet && flop_out && mode.ddr_out;
  endsequence

  sequence s_mode_write_read;
    (wr_mode && !reg_rd_i) ##1 (reg_rd_i && reg_addr_i == ADDR_MODE);
  endsequence

  a_ddr_upper_pad: assert property (@(posedge clk_i) disable iff (reset_i)
    s_out_upper_load ##1 (lvl[CK_OUT_UP] && !ck_rise[CK_OUT_UP])
      |=> (pad_o == $past(first_edge_bit_i, 2)))
    else $error("pad did not show the first bit while first clock high");

  a_ddr_lower_pad: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode.ddr_out && !lvl[CK_OUT_UP]) |=> (pad_o == $past(el_q[EL_OUT_LO])))
    else $error("pad did not show the lower register while clock low");

  a_oe_shared_clock: assert property (@(posedge clk_i) disable iff (reset_i)
    (ck_rise[CK_OUT_UP] && ce_oe && quiet && !el_cfg[EL_OE_UP].is_latch)
      |=> (el_q[EL_OE_UP] == $past(oe_first_edge_bit_i)))
    else $error("upper enable register missed the upper output clock");

  a_in_first_capture: assert property (@(posedge clk_i) disable iff (reset_i)
    (ck_rise[CK_IN_UP] && ce_in && quiet && flop_in)
      |=> ##1 (in_first_bit_o == $past(pad_sync, 2)))
    else $error("first input bit not captured on upper input clock");

  a_cascade_retime: assert property (@(posedge clk_i) disable iff (reset_i)
    (cascade_on && ck_rise[CK_IN_UP] && !ck_rise[CK_IN_LO] && ce_in
     && quiet && flop_in) |=> ##1 (in_second_bit_o == $past(el_q[EL_IN_LO], 2)))
    else $error("cascaded second bit not retimed to upper input clock");

  a_cascade_gated: assert property (@(posedge clk_i) disable iff (reset_i)
    !mode.diff_standard |=> (in_second_bit_o == $past(el_q[EL_IN_LO])))
    else $error("cascade used without a differential standard");

  a_mode_readback: assert property (@(posedge clk_i) disable iff (reset_i)
    s_mode_write_read |=> (reg_rdata_o[MODE_W-1:0] ==
                           $past(reg_wdata_i[MODE_W-1:0], 2)))
    else $error("mode register read back wrong");

  a_read_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !reg_rd_i |=> (reg_rdata_o == 32'h00000000))
    else $error("read data present without a read");

endmodule // ioc_cell
`default_nettype wire

/* tb/ioc_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ioc_src_model (
  output logic lclk_o,
  output logic data_o
);
  initial begin
    lclk_o = 1'h0;
    data_o = 1'h0;
  end
  // Two bit pairs, MSB first, one bit per half of a 320 ns period
  task automatic send(input logic [3:0] bits);
    for (int i = 3; i >= 0; i--) begin
      data_o <= bits[i];
      #80;
      lclk_o <= ~lclk_o;
      #80;
    end
    // Released line shows the inverse of the last bit
    data_o <= ~bits[0];
  endtask
endmodule // ioc_src_model
`default_nettype wire

/* tb/ioc_cell_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ioc_cell_tb;
  import ioc_pkg::*;
  logic              clk_i = '0;
  logic              reset_i = '1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic reg_wr_i = '0, reg_rd_i = '0, out_oe_clock_upper_i = '0;
  logic out_oe_clock_lower_i = '0, in_clock_lower_i = '0;
  logic out_path_clock_enable_i = '1, oe_path_clock_enable_i = '1;
  logic in_path_clock_enable_i = '1, force_line_i = '0;
  logic reverse_force_line_i = '0, global_force_i = '0;
  logic first_edge_bit_i = '0, second_edge_bit_i = '0;
  logic oe_first_edge_bit_i = '0, oe_second_edge_bit_i = '0;
  logic in_first_bit_o, in_second_bit_o, pad_o, pad_oe_n_o;
  wire logic in_clock_upper_i, pad_i;
  int n_errors = 0, compares = 0;

  always #20 clk_i = ~clk_i;

  ioc_cell dut_u (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .out_oe_clock_upper_i, .out_oe_clock_lower_i,
    .in_clock_upper_i, .in_clock_lower_i, .out_path_clock_enable_i,
    .oe_path_clock_enable_i, .in_path_clock_enable_i, .force_line_i,
    .reverse_force_line_i, .global_force_i, .first_edge_bit_i,
    .second_edge_bit_i, .oe_first_edge_bit_i, .oe_second_edge_bit_i,
    .in_first_bit_o, .in_second_bit_o, .pad_i, .pad_o, .pad_oe_n_o);
  ioc_src_model src_u (.lclk_o(in_clock_upper_i), .data_o(pad_i));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= '1;
    @(posedge clk_i);
    reg_wr_i <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= '1;
    @(posedge clk_i);
    reg_rd_i <= '0;
    @(negedge clk_i);
    chk("rdata", e, reg_rdata_o);
  endtask
  // Write then read the same address with no idle cycle between
  task automatic wr_rd(input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= '1;
    @(posedge clk_i);
    reg_wr_i <= '0;
    reg_rd_i <= '1;
    @(posedge clk_i);
    reg_rd_i <= '0;
    @(negedge clk_i);
    chk("rdata_b2b", e, reg_rdata_o);
  endtask
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(ADDR_MODE, 32'h0);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, 32'h0);
    wr_rd(ADDR_MODE, 32'h0000_0155, 32'h0000_0155);
    wr(ADDR_MODE, 32'hFFFF_FFFF);
    rd(ADDR_MODE, 32'h0000_01FF);
  endtask
  task automatic t_ddr_out;
    for (int inv = 1; inv >= 0; inv--) begin
      wr(ADDR_MODE, 32'h03 | (32'(inv) << 5));
      @(posedge clk_i);
      first_edge_bit_i <= '1;
      oe_second_edge_bit_i <= '1;
      out_path_clock_enable_i <= '0;
      oe_path_clock_enable_i <= '0;
      for (int h = 0; h < 6; h++) begin
        @(posedge clk_i);
        out_oe_clock_upper_i <= !h[0];
        out_oe_clock_lower_i <= (inv == 1) ? !h[0] : h[0];
        look(12);
        chk("pad", !h[0], pad_o);
        chk("oe_n", h[0], pad_oe_n_o);
      end
    end
  endtask
  task automatic t_force;
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_ELEM_CFG, 32'h0000_1806);
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_i);
      force_line_i <= k[0];
      reverse_force_line_i <= k[1];
      look(4);
      chk("force_pad", k == 1, pad_o);
      chk("force_oe", k == 1, pad_oe_n_o);
    end
    @(posedge clk_i);
    force_line_i <= '0;
    reverse_force_line_i <= '0;
  endtask
  task automatic t_init_ce;
    wr(ADDR_ELEM_CFG, 32'h0000_0018);
    wr(ADDR_MODE, 32'h0000_0040);
    @(posedge clk_i);
    global_force_i <= '1;
    first_edge_bit_i <= '0;
    @(posedge clk_i);
    global_force_i <= '0;
    look(4);
    chk("init", 1, pad_o);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_i);
      out_oe_clock_upper_i <= '1;
      look(8);
      chk("ce_gate", s == 0, pad_o);
      @(posedge clk_i);
      out_oe_clock_upper_i <= '0;
      out_path_clock_enable_i <= '1;
      look(8);
    end
  endtask
  task automatic t_ddr_in;
    logic [7:0] md [3] = '{8'h24, 8'h2C, 8'h3C};
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_MODE, 32'(md[c]));
      src_u.send(4'h9);
      look(10);
      chk("in_first", 0, in_first_bit_o);
      chk("in_second", c != 2, in_second_bit_o);
    end
  endtask
  task automatic t_latch;
    wr(ADDR_ELEM_CFG, 32'h0000_0001);
    wr(ADDR_MODE, 32'h0);
    @(posedge clk_i);
    out_oe_clock_upper_i <= '1;
    first_edge_bit_i <= '1;
    look(8);
    chk("latch_pass", 1, pad_o);
    @(posedge clk_i);
    first_edge_bit_i <= '0;
    look(4);
    chk("latch_follow", 0, pad_o);
    @(posedge clk_i);
    out_oe_clock_upper_i <= '0;
    look(8);
    @(posedge clk_i);
    first_edge_bit_i <= '1;
    look(4);
    chk("latch_hold", 0, pad_o);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= '0;
    t_regs();
    t_ddr_out();
    t_force();
    t_init_ce();
    t_ddr_in();
    t_latch();
    final_report();
  end
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
endmodule // ioc_cell_tb
`default_nettype wire
